// File: lineif_pkg.sv
// shared constants and types of the transmit input port
// assumes an apb master on pclk and a framer on the link clock
package lineif_pkg;
   localparam logic [31:0] LINEIF_CTRL_OFS   = 32'h0000_0000;
   localparam logic [31:0] LINEIF_STATUS_OFS = 32'h0000_0004;
   localparam logic [3:0]  LINEIF_CTRL_RST   = 4'h0;
   localparam int          LINEIF_SYNC_STAGES = 2;

   // control fields
   typedef struct packed {
      logic host_mode;
      logic dual_rail;
      logic edge_rise;
      logic sw_driver_disable_in;
   } lineif_ctrl_t;

   // one sampled bit pair
   typedef struct packed {
      logic pos;
      logic neg;
   } lineif_rail_t;

   // state returned to the bus domain
   typedef struct packed {
      logic         alive;
      logic         off;
      logic         edge_rise;
      logic         dual_rail;
      lineif_rail_t pair;
   } lineif_stat_t;
endpackage

// File: lineif_tx_input_port.sv
// transmit terminal input port of one line channel
// assumes framer rail data is timed to tx_line_clock, apb on pclk
// Operation
// - after reset both rails are sampled on the falling clock edge.
// - in host mode software picks rising or falling sampling edge.
// - in dual-rail a sampled one on the positive rail makes one positive pulse.
// - a sampled one on the negative rail makes one negative pulse.
// - negative rail held low in single-rail; treated as pulled down.
// - dual-rail samples the negative rail on the same edge as positive.
// - line pulses leave as a tip and ring pair.
// - transmitter-off input floats tip and ring in either mode.
`timescale 1ns/1ps
module lineif_tx_input_port
   import lineif_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tx_line_clock,
   input  wire logic        pos_rail_in,
   input  wire logic        neg_rail_in,
   input  wire logic        driver_disable_in,
   output logic             enc_data_out,
   input  wire logic        enc_pos_in,
   input  wire logic        enc_neg_in,
   output logic             line_tip_out,
   output logic             line_tip_oe,
   output logic             line_ring_out,
   output logic             line_ring_oe
);
   import lineif_pkg::*;

   lineif_ctrl_t ctrl_r;
   logic [31:0]  prdata_r;
   logic         pslverr_r;
   logic         setup;
   logic         acc_wr;
   logic         hit_ctrl;
   logic         hit_stat;
   lineif_stat_t stat_q1_r;
   lineif_stat_t stat_q2_r;

   logic         lrst_q1_r;
   logic         lrst_n;
   logic         ctrl_tgl_r;
   logic [2:0]   tgl_sync_r;
   lineif_ctrl_t ctrl_q2_r;
   logic         dis_q1_r;
   logic         dis_q2_r;
   lineif_rail_t fall_r;
   lineif_rail_t pair_r;
   lineif_rail_t pins;
   logic         use_rise;
   logic         tip_r;
   logic         ring_r;
   logic         off_r;
   logic         enc_r;
   logic         alive_r;
   lineif_stat_t stat_l;

   // apb decode
   assign setup    = psel && !penable;
   assign acc_wr   = psel && penable && pwrite;
   assign hit_ctrl = (paddr == LINEIF_CTRL_OFS);
   assign hit_stat = (paddr == LINEIF_STATUS_OFS);
   assign pready   = 1'b1;
   assign prdata   = prdata_r;
   assign pslverr  = pslverr_r;

   // control register, a toggle marks each write for the link side
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r     <= LINEIF_CTRL_RST;
         ctrl_tgl_r <= 1'b0;
      end
      else if (acc_wr && hit_ctrl)
      begin
         ctrl_r     <= pwdata[3:0];
         ctrl_tgl_r <= !ctrl_tgl_r;
      end
   end

   // read data and error, prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup)
      begin
         pslverr_r <= !(hit_ctrl || hit_stat);
         if (pwrite || !(hit_ctrl || hit_stat))
            prdata_r <= 32'h0000_0000;
         else if (hit_ctrl)
            prdata_r <= {28'h000_0000, ctrl_r};
         else
            prdata_r <= {26'h000_0000, stat_q2_r};
      end
   end

   // link state into the bus domain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_q1_r <= '0;
         stat_q2_r <= '0;
      end
      else
      begin
         stat_q1_r <= stat_l;
         stat_q2_r <= stat_q1_r;
      end
   end

   // reset release synchronised to the link clock
   always_ff @(posedge tx_line_clock or negedge presetn)
   begin
      if (!presetn)
      begin
         lrst_q1_r <= 1'b0;
         lrst_n    <= 1'b0;
      end
      else
      begin
         lrst_q1_r <= 1'b1;
         lrst_n    <= lrst_q1_r;
      end
   end

   // control taken whole once its write toggle is synchronised
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         tgl_sync_r <= 3'h0;
         ctrl_q2_r  <= LINEIF_CTRL_RST;
         dis_q1_r   <= 1'b0;
         dis_q2_r   <= 1'b0;
      end
      else
      begin
         tgl_sync_r <= {tgl_sync_r[1:0], ctrl_tgl_r};
         dis_q1_r   <= driver_disable_in;
         dis_q2_r   <= dis_q1_r;
         if (tgl_sync_r[1] != tgl_sync_r[2])
            ctrl_q2_r <= ctrl_r;
      end
   end

   // hardware mode forces the falling edge
   assign use_rise = ctrl_q2_r.host_mode && ctrl_q2_r.edge_rise;

   // single rail ignores the negative pin as if pulled down
   assign pins.pos = pos_rail_in;
   assign pins.neg = ctrl_q2_r.dual_rail && neg_rail_in;

   // falling edge sample
   always_ff @(negedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         fall_r <= '0;
      else
         fall_r <= pins;
   end

   // chosen pair, retimed to the rising edge
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         pair_r <= '0;
      else
         pair_r <= use_rise ? pins : fall_r;
   end

   // encoder feed in single rail
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         enc_r <= 1'b0;
      else
         enc_r <= pair_r.pos;
   end
   assign enc_data_out = enc_r;

   // pulse drive onto tip and ring
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         tip_r  <= 1'b0;
         ring_r <= 1'b0;
      end
      else if (ctrl_q2_r.dual_rail)
      begin
         tip_r  <= pair_r.pos;
         ring_r <= pair_r.neg;
      end
      else
      begin
         tip_r  <= enc_pos_in;
         ring_r <= enc_neg_in;
      end
   end

   // transmitter off, pin works in both modes
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         off_r <= 1'b1;
      else
         off_r <= dis_q2_r || (ctrl_q2_r.host_mode && ctrl_q2_r.sw_driver_disable_in);
   end

   assign line_tip_out  = tip_r && !off_r;
   assign line_ring_out = ring_r && !off_r;
   assign line_tip_oe   = !off_r;
   assign line_ring_oe  = !off_r;

   // activity toggle for status
   always_ff @(posedge tx_line_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         alive_r <= 1'b0;
      else
         alive_r <= !alive_r;
   end

   assign stat_l.alive     = alive_r;
   assign stat_l.off       = off_r;
   assign stat_l.edge_rise = use_rise;
   assign stat_l.dual_rail = ctrl_q2_r.dual_rail;
   assign stat_l.pair      = pair_r;

   sequence s_pos_taken;
      ctrl_q2_r.dual_rail && pair_r.pos;
   endsequence

   sequence s_neg_taken;
      ctrl_q2_r.dual_rail && pair_r.neg;
   endsequence

   property p_fall_default;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      !ctrl_q2_r.host_mode |=> pair_r == $past(fall_r);
   endproperty
   a_fall_default: assert property (p_fall_default)
      else $error("hardware mode did not use falling sample");

   property p_rise_sel;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      use_rise |=> pair_r.pos == $past(pos_rail_in);
   endproperty
   a_rise_sel: assert property (p_rise_sel)
      else $error("rising edge selection not honoured");

   property p_pos_pulse;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      s_pos_taken ##1 ctrl_q2_r.dual_rail && !off_r |-> line_tip_out;
   endproperty
   a_pos_pulse: assert property (p_pos_pulse)
      else $error("positive one gave no tip pulse");

   property p_neg_pulse;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      s_neg_taken ##1 ctrl_q2_r.dual_rail && !off_r |-> line_ring_out;
   endproperty
   a_neg_pulse: assert property (p_neg_pulse)
      else $error("negative one gave no ring pulse");

   property p_single_neg;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      !ctrl_q2_r.dual_rail [*2] |-> !pair_r.neg;
   endproperty
   a_single_neg: assert property (p_single_neg)
      else $error("negative rail leaked in single rail");

   property p_dual_same_edge;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      ctrl_q2_r.dual_rail && use_rise |=>
         pair_r == {$past(pos_rail_in), $past(neg_rail_in)};
   endproperty
   a_dual_same_edge: assert property (p_dual_same_edge)
      else $error("rails not sampled on the same edge");

   property p_tip_ring;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      ctrl_q2_r.dual_rail |=> {tip_r, ring_r} == $past(pair_r);
   endproperty
   a_tip_ring: assert property (p_tip_ring)
      else $error("tip and ring do not follow the rails");

   property p_off;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      dis_q2_r |=> !line_tip_oe && !line_ring_oe;
   endproperty
   a_off: assert property (p_off)
      else $error("driver off pin did not float outputs");

   property p_latency;
      @(posedge tx_line_clock) disable iff (!lrst_n)
      s_pos_taken |=> tip_r ##1 1'b1;
   endproperty
   a_latency: assert property (p_latency)
      else $error("positive bit not forwarded in one cycle");

   property p_apb_err;
      @(posedge pclk) disable iff (!presetn)
      setup && !(hit_ctrl || hit_stat) |=> pslverr;
   endproperty
   a_apb_err: assert property (p_apb_err)
      else $error("unmapped access gave no error");
endmodule

// File: lineif_framer_model.sv
// framer model: drives rail data from the link clock
// assumes the bench gives the clock, drive edge and rail mode
`timescale 1ns/1ps
module lineif_framer_model (
   input  wire logic clk,
   input  wire logic fall_drive,
   input  wire logic dual,
   output logic      pos,
   output logic      neg
);
   logic [31:0] lfsr_r = 32'h20c8;
   function automatic logic [31:0] lfsr_f(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic drive_bits();
      lfsr_r <= lfsr_f(lfsr_r);
      pos    <= lfsr_r[3];
      neg    <= dual & lfsr_r[7];
   endtask
   initial pos = 1'b0;
   initial neg = 1'b0;
   always @(posedge clk) if (!fall_drive) drive_bits();
   always @(negedge clk) if (fall_drive) drive_bits();
endmodule

// File: lineif_tx_input_port_tb.sv
// self-checking bench of the transmit input port
// assumes the framer model and the design package
`timescale 1ns/1ps
module lineif_tx_input_port_tb;
   import lineif_pkg::*;
   logic        pclk = 1'b0;
   logic        lclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, pos, neg, enc_d;
   logic        tip, tip_oe, ring, ring_oe;
   logic        off_in = 1'b0;
   logic        fall_drive = 1'b0;
   logic        dual = 1'b0;
   logic        chk_en = 1'b0;
   int          lag = 3;
   int          err_count = 0;
   int          total_checks = 0;
   logic [32:0] rd_q[$];
   logic [32:0] e;
   logic [1:0]  exp_q[$];
   logic [1:0]  le;
   wire  [3:0]  line_v = {tip_oe, ring_oe, tip, ring};

   initial forever #12.5 pclk = ~pclk;
   initial
   begin
      #7;
      forever #32 lclk = ~lclk;
   end

   lineif_tx_input_port u_dut (
      .pclk              (pclk),
      .presetn           (presetn),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .paddr             (paddr),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .tx_line_clock     (lclk),
      .pos_rail_in       (pos),
      .neg_rail_in       (neg),
      .driver_disable_in (off_in),
      .enc_data_out      (enc_d),
      .enc_pos_in        (enc_d),
      .enc_neg_in        (1'b0),
      .line_tip_out      (tip),
      .line_tip_oe       (tip_oe),
      .line_ring_out     (ring),
      .line_ring_oe      (ring_oe)
   );
   lineif_framer_model u_framer (
      .clk        (lclk),
      .fall_drive (fall_drive),
      .dual       (dual),
      .pos        (pos),
      .neg        (neg)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [32:0] x);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      rd_q.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_count++;
         finish_test();
      end
      else
      begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic phase(input logic [3:0] c, input logic fd,
                        input logic dl, input int lg);
      apb(1'b1, LINEIF_CTRL_OFS, {28'h0, c}, 33'h0);
      @(posedge lclk);
      fall_drive <= fd;
      dual       <= dl;
      lag = lg;
      repeat (8) @(posedge lclk);
      #2;
      exp_q.delete();
      chk_en = 1'b1;
      repeat (40) @(posedge lclk);
      chk_en = 1'b0;
      $display("mode %h test done", c);
   endtask
   task automatic wait_oe(input logic want);
      int n;
      n = 0;
      while (tip_oe !== want && n < 20)
      begin
         @(posedge lclk);
         n++;
      end
      #1;
      if (n >= 20)
      begin
         err_count++;
         finish_test();
      end
      else
         check(32'(line_v & {2'b11, ~want, ~want}), {28'h0, want, want, 2'b0});
   endtask

   always @(posedge pclk)
      if (psel && penable && pready === 1'b1)
      begin
         e = rd_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]});
         if (!pwrite)
            check(prdata, e[31:0]);
      end
   always @(posedge lclk)
   begin
      #1;
      if (!fall_drive)
         exp_q.push_back({pos, neg});
      if (chk_en && exp_q.size() >= lag)
      begin
         le = exp_q.pop_front();
         if (dual)
            check(32'(line_v), {28'h0, 2'b11, le});
         else
            check({31'h0, enc_d}, {31'h0, le[1]});
      end
   end
   always @(negedge lclk)
   begin
      #1;
      if (fall_drive)
         exp_q.push_back({pos, neg});
   end

   initial
   begin
      repeat (100000) @(posedge pclk);
      err_count++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, LINEIF_CTRL_OFS, 32'h0, {29'h0, LINEIF_CTRL_RST});
      apb(1'b0, 32'h8, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 32'hc, 32'hf, {1'b1, 32'h0});
      apb(1'b1, LINEIF_STATUS_OFS, 32'hff, 33'h0);
      $display("register test done");
      phase(4'h0, 1'b0, 1'b0, 3);
      phase(4'h4, 1'b0, 1'b1, 3);
      apb(1'b0, LINEIF_CTRL_OFS, 32'h0, 33'h4);
      phase(4'he, 1'b1, 1'b1, 2);
      phase(4'h6, 1'b0, 1'b1, 3);
      phase(4'hc, 1'b0, 1'b1, 3);
      @(posedge lclk);
      off_in <= 1'b1;
      wait_oe(1'b0);
      @(posedge lclk);
      off_in <= 1'b0;
      wait_oe(1'b1);
      apb(1'b1, LINEIF_CTRL_OFS, 32'hd, 33'h0);
      wait_oe(1'b0);
      apb(1'b1, LINEIF_CTRL_OFS, 32'h1, 33'h0);
      wait_oe(1'b1);
      $display("off test done");
      finish_test();
   end
endmodule
